/* rtl/counter_array_regs.vh */
// Register map, field layout and timing constants of the counter array timebase block
`ifndef COUNTER_ARRAY_REGS_VH
`define COUNTER_ARRAY_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MODE_OFFSET 12'h000
`define CONTROL_OFFSET 12'h004
`define COUNT_OFFSET 12'h008

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_IRQ_EN_BIT 0
`define MODE_SEL_LSB 1
`define MODE_SEL_MSB 3
`define MODE_WDOG_BIT 6
`define MODE_RESET 8'h00
`define MODE_WIDTH 8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_RUN_BIT 6
`define CTRL_FLAG_BIT 7

// ----------------------------------------
// Timebase select codes
// ----------------------------------------
`define SEL_DIV12 3'h0
`define SEL_DIV4 3'h1
`define SEL_T0 3'h2
`define SEL_EXT_IN 3'h3
`define SEL_SYSCLK 3'h4
`define SEL_EXT_DIV8 3'h5

// ----------------------------------------
// Prescaler division ratios
// ----------------------------------------
`define DIV12_LAST 4'hb
`define DIV4_LAST 4'h3
`define EXT_DIV8_LAST 3'h7

`endif

/* rtl/pulse_sync.v */
// Two-stage synchroniser with rising or falling edge pulse output
module pulse_sync #(
    parameter FALLING = 1'b0
) (
    input wire pclk,
    input wire presetn,
    input wire din,
    output reg pulse
);

    // Reset to the level that the watched edge ends on, so a pin already there at release gives no false pulse
    localparam IDLE_LEVEL = FALLING ? 1'b0 : 1'b1;

    reg meta_r;
    reg sync_r;
    reg prev_r;

    // ----------------------------------------
    // Synchroniser and edge detector
    // ----------------------------------------
    // Only sync_r and prev_r feed the detector; meta_r is read by sync_r alone
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= IDLE_LEVEL;
            sync_r <= IDLE_LEVEL;
            prev_r <= IDLE_LEVEL;
            pulse <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            prev_r <= sync_r;
            pulse <= FALLING ? (prev_r & ~sync_r) : (sync_r & ~prev_r);
        end
    end

endmodule

/* rtl/counter_array_timebase.v */
// Counter array timebase selection, 16-bit counter, overflow flag and interrupt gate behind APB
`include "counter_array_regs.vh"

// Functional notes
// - The select field picks sysclk/12, sysclk/4, timer 0 overflow, external input falling edges, sysclk or ext clock/8.
// - The external oscillator is synchronised to the system clock and then divided by eight on it before it advances the counter.
// - Bit 0 of the mode register gates the overflow flag onto the overflow interrupt request.
// - While the watchdog enable bit is 1, writes to the mode register are ignored.
module counter_array_timebase #(
    parameter CNT_WIDTH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire timer0_overflow,
    input wire external_count_input,
    input wire ext_osc_clk,
    output reg overflow_irq
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [`MODE_WIDTH-1:0] counter_array_mode_r;
    reg run_r;
    reg counter_overflow_flag_r;
    reg [CNT_WIDTH-1:0] count_r;
    reg [3:0] presc_r;
    reg [2:0] ext_div_r;
    reg t0_meta_r;
    reg t0_sync_r;
    reg [CNT_WIDTH-1:0] count_nxt;
    reg tick;
    reg [31:0] rdata_nxt;
    wire ext_fall_pulse;
    wire ext_div8_pulse;
    wire ext_osc_rise;
    wire [2:0] count_pulse_select;
    wire overflow_irq_enable;
    wire watchdog_enable;
    wire wr_en;
    wire rd_en;
    wire wrap;

    // Address decode used by both the write path and the read path
    function hit;
        input [11:0] addr;
        input [11:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    assign count_pulse_select = counter_array_mode_r[`MODE_SEL_MSB:`MODE_SEL_LSB];
    assign overflow_irq_enable = counter_array_mode_r[`MODE_IRQ_EN_BIT];
    assign watchdog_enable = counter_array_mode_r[`MODE_WDOG_BIT];
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    // ----------------------------------------
    // Timebase sources
    // ----------------------------------------
    // External count input: falling edges after a two-flop synchroniser
    pulse_sync #(.FALLING(1'b1)) u_ext_in (
        .pclk(pclk),
        .presetn(presetn),
        .din(external_count_input),
        .pulse(ext_fall_pulse)
    );

    // External oscillator: rising edges are brought into pclk before anything counts them
    pulse_sync #(.FALLING(1'b0)) u_ext_osc (
        .pclk(pclk),
        .presetn(presetn),
        .din(ext_osc_clk),
        .pulse(ext_osc_rise)
    );

    // ----------------------------------------
    // Oscillator divider
    // ----------------------------------------
    // Dividing on pclk keeps the block on one clock; the cost is that the oscillator
    // must stay well below half the pclk rate, or edges slip through the synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_div_r <= 3'h0;
        end else if (ext_osc_rise) begin
            ext_div_r <= ext_div_r + 3'h1;
        end
    end

    // Every eighth synchronised oscillator edge is one timebase pulse
    assign ext_div8_pulse = ext_osc_rise & (ext_div_r == `EXT_DIV8_LAST);

    // ----------------------------------------
    // Timer 0 input
    // ----------------------------------------
    // Timer 0 overflow is treated as asynchronous, so it passes two flops
    // before the multiplexer may read it; this costs two cycles of latency
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_meta_r <= 1'b0;
            t0_sync_r <= 1'b0;
        end else begin
            t0_meta_r <= timer0_overflow;
            t0_sync_r <= t0_meta_r;
        end
    end

    // System clock prescaler; wraps at 12 or 4 depending on the select
    // A value left above the divide-by-four limit by another select wraps at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 4'h0;
        end else if (!run_r) begin
            presc_r <= 4'h0;
        end else if ((count_pulse_select == `SEL_DIV12 && presc_r == `DIV12_LAST) ||
                     (count_pulse_select == `SEL_DIV4 && presc_r >= `DIV4_LAST)) begin
            presc_r <= 4'h0;
        end else begin
            presc_r <= presc_r + 4'h1;
        end
    end

    // ----------------------------------------
    // Timebase multiplexer
    // ----------------------------------------
    // Reserved codes select nothing so the counter holds
    always @* begin
        case (count_pulse_select)
            `SEL_DIV12: tick = (presc_r == `DIV12_LAST);
            `SEL_DIV4: tick = (presc_r == `DIV4_LAST);
            `SEL_T0: tick = t0_sync_r;
            `SEL_EXT_IN: tick = ext_fall_pulse;
            `SEL_SYSCLK: tick = 1'b1;
            `SEL_EXT_DIV8: tick = ext_div8_pulse;
            default: tick = 1'b0;
        endcase
    end

    assign wrap = run_r & tick & (count_r == {CNT_WIDTH{1'b1}});

    always @* begin
        count_nxt = count_r;
        if (run_r && tick) begin
            count_nxt = count_r + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------
    // Register writes, counter and flag
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_array_mode_r <= `MODE_RESET;
            run_r <= 1'b0;
            counter_overflow_flag_r <= 1'b0;
            count_r <= {CNT_WIDTH{1'b0}};
        end else begin
            // Mode register is frozen while the watchdog bit is set
            if (wr_en && hit(paddr, `MODE_OFFSET) && !watchdog_enable) begin
                counter_array_mode_r <= pwdata[`MODE_WIDTH-1:0];
            end
            if (wr_en && hit(paddr, `CONTROL_OFFSET)) begin
                run_r <= pwdata[`CTRL_RUN_BIT];
            end
            // A wrap in the same cycle as a software clear keeps the flag set
            if (wrap) begin
                counter_overflow_flag_r <= 1'b1;
            end else if (wr_en && hit(paddr, `CONTROL_OFFSET)) begin
                counter_overflow_flag_r <= pwdata[`CTRL_FLAG_BIT];
            end
            if (wr_en && hit(paddr, `COUNT_OFFSET)) begin
                count_r <= pwdata[CNT_WIDTH-1:0];
            end else begin
                count_r <= count_nxt;
            end
        end
    end

    // ----------------------------------------
    // Read path and bus answer
    // ----------------------------------------
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (hit(paddr, `MODE_OFFSET)) begin
            rdata_nxt[`MODE_WIDTH-1:0] = counter_array_mode_r;
        end else if (hit(paddr, `CONTROL_OFFSET)) begin
            rdata_nxt[`CTRL_FLAG_BIT] = counter_overflow_flag_r;
            rdata_nxt[`CTRL_RUN_BIT] = run_r;
        end else if (hit(paddr, `COUNT_OFFSET)) begin
            rdata_nxt[CNT_WIDTH-1:0] = count_r;
        end
    end

    // Registered answer: pready rises in the first access cycle, so no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~(hit(paddr, `MODE_OFFSET) | hit(paddr, `CONTROL_OFFSET) |
                       hit(paddr, `COUNT_OFFSET));
            if (rd_en) begin
                prdata <= rdata_nxt;
            end
            overflow_irq <= overflow_irq_enable & counter_overflow_flag_r;
        end
    end

endmodule

/* bench/counter_array_monitor.sv */
// Port-level checker for the counter array timebase block
module counter_array_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire overflow_irq
);
    reg [7:0] mode_r;
    wire wr_mode = psel && penable && pready && pwrite && paddr == 12'h000;
    // Shadow of the mode register; once the watchdog bit is set only reset frees it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_r <= 8'h00;
        else if (wr_mode && !mode_r[6])
            mode_r <= pwdata[7:0];
    end
    default clocking ck @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready held too long");
    no_wait_state_a: assert property (psel && !penable |=> pready) else $error("access phase longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access phase");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read not 0");
    mode_lock_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, mode_r})
        else $error("mode register read differs from shadow");
    irq_masked_a: assert property (!mode_r[0] |=> !overflow_irq) else $error("masked interrupt raised");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
    cover property (wr_mode && mode_r[6]);
    cover property ($rose(overflow_irq));
    cover property (pready && pslverr);
endmodule

bind counter_array_timebase counter_array_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overflow_irq(overflow_irq));

/* bench/test_counter_array_timebase.sv */
// Self-checking bench for the counter array timebase block
`include "counter_array_regs.vh"
module test_counter_array_timebase;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic t0 = 1'h0, ext = 1'h1, osc = 1'h0, pready, pslverr, overflow_irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, c0;
    int fails = 0, samples_checked = 0, cyc = 0;
    int ticks[8] = '{10, 30, 5, 10, 120, 5, 0, 0};
    counter_array_timebase i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_overflow(t0), .external_count_input(ext), .ext_osc_clk(osc), .overflow_irq(overflow_irq));
    initial forever #2 pclk = ~pclk;
    // Hang guard; the sequence needs under 2000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task summarize();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; pready, read data and the error bit are taken at the same rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        check(pslverr, err);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0, a > `COUNT_OFFSET);
        check(rd, exp);
    endtask
    // Count sources: timer pulses, falling edges at an eighth of the clock, oscillator edges
    task stim(input int s);
        for (int i = 0; i < 80; i++) begin
            @(posedge pclk);
            if (s == 2) t0 <= (i % 16 == 0);
            if (s == 3) ext <= (i % 8 < 4);
            if (s == 5) osc <= i[0];
        end
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        osc <= 1'h1;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(`MODE_OFFSET, 32'h0);
        rdchk(`CONTROL_OFFSET, 32'h0);
        rdchk(`COUNT_OFFSET, 32'h0);
        rdchk(12'h010, 32'h0);
        apb(1'h1, 12'h010, 32'h1, 1'h1);
        $display("test reset and map done");
        // Every select code, measured between two reads exactly 120 cycles apart
        apb(1'h1, `CONTROL_OFFSET, 32'h40, 1'h0);
        for (int s = 0; s < 8; s++) begin
            apb(1'h1, `MODE_OFFSET, s << 1, 1'h0);
            apb(1'h0, `COUNT_OFFSET, 32'h0, 1'h0);
            c0 = rd;
            fork
                repeat (117) @(posedge pclk);
                stim(s);
            join
            apb(1'h0, `COUNT_OFFSET, 32'h0, 1'h0);
            check(rd - c0, ticks[s]);
        end
        $display("test timebase select done");
        apb(1'h1, `MODE_OFFSET, 32'h09, 1'h0);
        apb(1'h1, `COUNT_OFFSET, 32'hfff0, 1'h0);
        repeat (30) @(negedge pclk);
        check(overflow_irq, 32'h1);
        rdchk(`CONTROL_OFFSET, 32'hc0);
        apb(1'h1, `MODE_OFFSET, 32'h08, 1'h0);
        repeat (2) @(negedge pclk);
        check(overflow_irq, 32'h0);
        apb(1'h1, `MODE_OFFSET, 32'h09, 1'h0);
        apb(1'h1, `CONTROL_OFFSET, 32'h40, 1'h0);
        repeat (2) @(negedge pclk);
        check(overflow_irq, 32'h0);
        rdchk(`CONTROL_OFFSET, 32'h40);
        $display("test overflow interrupt done");
        apb(1'h1, `MODE_OFFSET, 32'h4b, 1'h0);
        apb(1'h1, `MODE_OFFSET, 32'h00, 1'h0);
        rdchk(`MODE_OFFSET, 32'h4b);
        // Only a reset frees the locked mode register
        presetn <= 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(`MODE_OFFSET, 32'h0);
        $display("test mode lock done");
        summarize();
    end
endmodule
